// ---- scr_pkg.sv ----
// Package: register indices, field positions and carrier types of the SCSI core register map
package scr_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_DEST_ID     = 10'h006;
  localparam logic [9:0] IDX_OUT_CTL     = 10'h009;
  localparam logic [9:0] IDX_INT_STATUS  = 10'h014;
  localparam logic [9:0] IDX_CT0         = 10'h018;
  localparam logic [9:0] IDX_CT1         = 10'h019;
  localparam logic [9:0] IDX_CT2         = 10'h01A;
  localparam logic [9:0] IDX_CT3         = 10'h01B;
  localparam logic [9:0] IDX_CT4         = 10'h021;
  localparam logic [9:0] IDX_CT5         = 10'h022;
  localparam logic [9:0] IDX_CT6         = 10'h023;
  localparam logic [9:0] IDX_INT_EN      = 10'h040;
  localparam logic [9:0] IDX_LPAR        = 10'h044;
  localparam logic [9:0] IDX_IN_LATCH    = 10'h050;
  localparam logic [9:0] IDX_OUT_LATCH   = 10'h054;
  localparam logic [9:0] IDX_BUS_LINES   = 10'h058;
  localparam logic [9:0] IDX_XFER        = 10'h005;
  localparam logic [9:0] IDX_CTL1        = 10'h001;
  localparam logic [9:0] IDX_CTL3        = 10'h003;
  localparam logic [9:0] IDX_EVT0        = 10'h042;
  localparam logic [9:0] IDX_TEST1       = 10'h04D;
  localparam logic [9:0] IDX_TEST2       = 10'h04E;
  localparam logic [9:0] IDX_CLK_CTL     = 10'h04F;
  localparam logic [9:0] IDX_SCRATCH2    = 10'h05C;

  // ==========================================================================
  // Field positions
  localparam int XFER_PERIOD_LO   = 5;
  localparam int CTL1_NO_HALT     = 5;
  localparam int CTL3_DIV_LO      = 4;
  localparam int EVT_BUS_RST      = 1;
  localparam int EVT_UNEXP_DISC   = 2;
  localparam int EVT_GROSS_ERR    = 3;
  localparam int EVT_FUNC_CMP     = 6;
  localparam int EVT_PHASE_MIS    = 7;
  localparam int CT2_DIRECTION    = 7;
  localparam int TEST1_FIFO_PAR   = 0;
  localparam int TEST2_OFS_RST    = 6;
  localparam int TEST2_LOOPBACK   = 4;
  localparam int TEST2_HIZ        = 3;
  localparam int TEST2_LOW_LEVEL  = 0;
  localparam int CLK_CTL_HALT     = 0;
  localparam int CLK_CTL_HALTED   = 1;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic bus_reset;
    logic unexp_disc;
    logic gross_err;
    logic func_cmp;
    logic phase_mis;
  } scr_evt_type;

  typedef struct packed {
    logic [2:0] xfer_period;
    logic [2:0] sync_div;
    logic       no_halt_on_err;
    logic       loopback;
    logic       low_level;
    logic       offset_reset;
    logic       clk_halt;
  } scr_cfg_type;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              aw_hold;
    logic [9:0]        aw_idx;
    logic              w_hold;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        dest_id;
    logic [7:0]        out_ctl;
    logic [7:0]        int_status;
    logic [6:0][7:0]   chip_test;
    logic [7:0]        int_en;
    logic [7:0]        lpar;
    logic [15:0]       in_latch;
    logic [15:0]       out_latch;
    logic [31:0]       scratch2;
    logic [7:0]        xfer;
    logic [7:0]        ctl1;
    logic [7:0]        ctl3;
    logic [7:0]        evt0;
    logic [7:0]        test2;
    logic              clk_halt;
    logic              ofs_rst;
    logic [15:0]       data_out;
    logic              data_oe;
    logic [7:0]        ctl_out;
    logic              ctl_oe;
  } scr_state_type;

  typedef struct packed {
    logic sclk;
  } scr_clk_state_type;

endpackage : scr_pkg

// ---- scr_clk_halt.sv ----
// Glitch-free halt and restart of the divided SCSI core clock
`timescale 1ns/1ps
`default_nettype none

module scr_clk_halt
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic halt,
  // Clock out
  output logic      sclk,
  output logic      halted
);

  // ==========================================================================
  // State
  scr_pkg::scr_clk_state_type st_q;
  scr_pkg::scr_clk_state_type st_d;
  logic                       halted_q;
  logic                       halted_d;

  // High phase always completes; halt only takes effect from a low phase
  always_comb
  begin
    st_d     = st_q;
    halted_d = halted_q;
    if (st_q.sclk)
    begin
      st_d.sclk = 1'b0;
    end
    else if (halt)
    begin
      halted_d = 1'b1;
    end
    else
    begin
      st_d.sclk = 1'b1;
      halted_d  = 1'b0;
    end
  end

  // Registered copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q     <= '0;
      halted_q <= 1'b0;
    end
    else
    begin
      st_q     <= st_d;
      halted_q <= halted_d;
    end
  end

  assign sclk   = st_q.sclk;
  assign halted = halted_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rise;
    !sclk ##1 sclk;
  endsequence

  a_full_high_phase: assert property (s_rise |=> !sclk)
    else $error("clock high phase was not one full cycle");
  a_halted_low_clk: assert property (halted && halt |=> !sclk)
    else $error("clock moved while halted");
  a_restart_clean: assert property (halted && !halt |=> sclk ##1 !sclk)
    else $error("restart did not give a full pulse");

endmodule : scr_clk_halt

`default_nettype wire

// ---- scr_regmap.sv ----
// Top: AXI4-Lite register map, data latches and test controls of the SCSI core
`timescale 1ns/1ps
`default_nettype none

module scr_regmap
(
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [11:0]           s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // AXI4-Lite write response
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [11:0]           s_axi_araddr,
  // AXI4-Lite read data
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  // SCSI data and control lines
  input  wire logic [15:0]           scsi_data_in,
  output logic [15:0]                scsi_data_out,
  output logic                       scsi_data_oe,
  output logic [7:0]                 scsi_ctl_out,
  output logic                       scsi_ctl_oe,
  // Core side
  input  wire logic                  rx_strobe,
  input  wire logic                  tx_active,
  input  wire logic                  ctl_drive,
  input  wire logic                  fifo_parity_lo,
  input  wire scr_pkg::scr_evt_type  events,
  output scr_pkg::scr_cfg_type       cfg,
  output logic                       scsi_clk
);

  // ==========================================================================
  // State and helpers
  scr_pkg::scr_state_type st_q;
  scr_pkg::scr_state_type st_d;
  logic                   clk_halted;
  logic [15:0]            bus_view;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // True when the index is one of the mapped registers
  function automatic logic mapped(input logic [9:0] idx);
    unique case (idx)
      scr_pkg::IDX_DEST_ID, scr_pkg::IDX_OUT_CTL, scr_pkg::IDX_INT_STATUS,
      scr_pkg::IDX_CT0, scr_pkg::IDX_CT1, scr_pkg::IDX_CT2, scr_pkg::IDX_CT3,
      scr_pkg::IDX_CT4, scr_pkg::IDX_CT5, scr_pkg::IDX_CT6, scr_pkg::IDX_INT_EN,
      scr_pkg::IDX_LPAR, scr_pkg::IDX_IN_LATCH, scr_pkg::IDX_OUT_LATCH,
      scr_pkg::IDX_BUS_LINES, scr_pkg::IDX_XFER, scr_pkg::IDX_CTL1,
      scr_pkg::IDX_CTL3, scr_pkg::IDX_EVT0, scr_pkg::IDX_TEST1,
      scr_pkg::IDX_TEST2, scr_pkg::IDX_CLK_CTL, scr_pkg::IDX_SCRATCH2:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  // Loopback feeds the driven data back to the internal view
  assign bus_view = st_q.test2[scr_pkg::TEST2_LOOPBACK] ? st_q.data_out : scsi_data_in;

  // ==========================================================================
  // Clock halt
  scr_clk_halt u_clk_halt
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .halt    (st_q.clk_halt),
    .sclk    (scsi_clk),
    .halted  (clk_halted)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [31:0] wm;
    logic [31:0] rv;
    logic [9:0]  ridx;
    logic [7:0]  sist_clr;
    wm       = '0;
    rv       = '0;
    ridx     = s_axi_araddr[11:2];
    sist_clr = '0;
    st_d         = st_q;
    st_d.ofs_rst = 1'b0;

    // Write address and data taken in either order
    if (st_q.awready && s_axi_awvalid)
    begin
      st_d.aw_hold = 1'b1;
      st_d.aw_idx  = s_axi_awaddr[11:2];
    end
    if (st_q.wready && s_axi_wvalid)
    begin
      st_d.w_hold = 1'b1;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready)
    begin
      st_d.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (st_q.aw_hold && st_q.w_hold)
    begin
      st_d.aw_hold = 1'b0;
      st_d.w_hold  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = mapped(st_q.aw_idx) ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
      wm = merge('0, st_q.wdata, st_q.wstrb);
      unique case (st_q.aw_idx)
        scr_pkg::IDX_DEST_ID:    if (st_q.wstrb[0]) st_d.dest_id = wm[7:0];
        scr_pkg::IDX_OUT_CTL:    if (st_q.wstrb[0]) st_d.out_ctl = wm[7:0];
        scr_pkg::IDX_INT_STATUS: if (st_q.wstrb[0]) st_d.int_status = wm[7:0];
        scr_pkg::IDX_CT0:        if (st_q.wstrb[0]) st_d.chip_test[0] = wm[7:0];
        scr_pkg::IDX_CT1:        if (st_q.wstrb[0]) st_d.chip_test[1] = wm[7:0];
        scr_pkg::IDX_CT2:        if (st_q.wstrb[0]) st_d.chip_test[2] = wm[7:0];
        scr_pkg::IDX_CT3:        if (st_q.wstrb[0]) st_d.chip_test[3] = wm[7:0];
        scr_pkg::IDX_CT4:        if (st_q.wstrb[0]) st_d.chip_test[4] = wm[7:0];
        scr_pkg::IDX_CT5:        if (st_q.wstrb[0]) st_d.chip_test[5] = wm[7:0];
        scr_pkg::IDX_CT6:        if (st_q.wstrb[0]) st_d.chip_test[6] = wm[7:0];
        scr_pkg::IDX_INT_EN:     if (st_q.wstrb[0]) st_d.int_en = wm[7:0];
        scr_pkg::IDX_LPAR:       if (st_q.wstrb[0]) st_d.lpar = wm[7:0];
        scr_pkg::IDX_OUT_LATCH:
          st_d.out_latch = 16'(merge({16'h0000, st_q.out_latch}, st_q.wdata, st_q.wstrb));
        scr_pkg::IDX_SCRATCH2:
          st_d.scratch2 = merge(st_q.scratch2, st_q.wdata, st_q.wstrb);
        scr_pkg::IDX_XFER:       if (st_q.wstrb[0]) st_d.xfer = wm[7:0];
        scr_pkg::IDX_CTL1:       if (st_q.wstrb[0]) st_d.ctl1 = wm[7:0];
        scr_pkg::IDX_CTL3:       if (st_q.wstrb[0]) st_d.ctl3 = wm[7:0];
        scr_pkg::IDX_TEST2:
          if (st_q.wstrb[0])
          begin
            st_d.test2 = wm[7:0] & 8'hBF;
            st_d.ofs_rst = wm[scr_pkg::TEST2_OFS_RST];
          end
        scr_pkg::IDX_CLK_CTL:
          if (st_q.wstrb[0]) st_d.clk_halt = wm[scr_pkg::CLK_CTL_HALT];
        default:
          st_d.bresp = st_d.bresp;
      endcase
    end

    // Read decode
    unique case (ridx)
      scr_pkg::IDX_DEST_ID:    rv = {24'h000000, st_q.dest_id};
      scr_pkg::IDX_OUT_CTL:    rv = {24'h000000, st_q.out_ctl};
      scr_pkg::IDX_INT_STATUS: rv = {24'h000000, st_q.int_status};
      scr_pkg::IDX_CT0:        rv = {24'h000000, st_q.chip_test[0]};
      scr_pkg::IDX_CT1:        rv = {24'h000000, st_q.chip_test[1]};
      scr_pkg::IDX_CT2:        rv = {24'h000000, st_q.data_oe, st_q.chip_test[2][6:0]};
      scr_pkg::IDX_CT3:        rv = {24'h000000, st_q.chip_test[3]};
      scr_pkg::IDX_CT4:        rv = {24'h000000, st_q.chip_test[4]};
      scr_pkg::IDX_CT5:        rv = {24'h000000, st_q.chip_test[5]};
      scr_pkg::IDX_CT6:        rv = {24'h000000, st_q.chip_test[6]};
      scr_pkg::IDX_INT_EN:     rv = {24'h000000, st_q.int_en};
      scr_pkg::IDX_LPAR:       rv = {24'h000000, st_q.lpar};
      scr_pkg::IDX_IN_LATCH:   rv = {16'h0000, st_q.in_latch};
      scr_pkg::IDX_OUT_LATCH:  rv = {16'h0000, st_q.out_latch};
      scr_pkg::IDX_BUS_LINES:  rv = {16'h0000, bus_view};
      scr_pkg::IDX_XFER:       rv = {24'h000000, st_q.xfer};
      scr_pkg::IDX_CTL1:       rv = {24'h000000, st_q.ctl1};
      scr_pkg::IDX_CTL3:       rv = {24'h000000, st_q.ctl3};
      scr_pkg::IDX_EVT0:       rv = {24'h000000, st_q.evt0};
      scr_pkg::IDX_TEST1:      rv = {31'h00000000, fifo_parity_lo};
      scr_pkg::IDX_TEST2:      rv = {24'h000000, st_q.test2};
      scr_pkg::IDX_CLK_CTL:    rv = {30'h00000000, clk_halted, st_q.clk_halt};
      scr_pkg::IDX_SCRATCH2:   rv = st_q.scratch2;
      default:                 rv = '0;
    endcase

    // Read channel
    if (st_q.rvalid && s_axi_rready)
    begin
      st_d.rvalid = 1'b0;
    end
    if (st_q.arready && s_axi_arvalid)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata  = rv;
      st_d.rresp  = mapped(ridx) ? scr_pkg::RESP_OKAY : scr_pkg::RESP_SLVERR;
      if (ridx == scr_pkg::IDX_EVT0)
      begin
        sist_clr = 8'hFF;
      end
    end

    // Sticky status: clear on read, a new event wins
    st_d.evt0 = (st_q.evt0 & ~sist_clr)
              | ({7'h00, events.bus_reset}  << scr_pkg::EVT_BUS_RST)
              | ({7'h00, events.unexp_disc} << scr_pkg::EVT_UNEXP_DISC)
              | ({7'h00, events.gross_err}  << scr_pkg::EVT_GROSS_ERR)
              | ({7'h00, events.func_cmp}   << scr_pkg::EVT_FUNC_CMP)
              | ({7'h00, events.phase_mis}  << scr_pkg::EVT_PHASE_MIS);

    // Data latches and line drive
    if (rx_strobe)
    begin
      st_d.in_latch = bus_view;
    end
    st_d.data_out = st_d.out_latch;
    st_d.data_oe  = tx_active && !st_d.test2[scr_pkg::TEST2_HIZ];
    st_d.ctl_out  = st_d.out_ctl;
    st_d.ctl_oe   = ctl_drive && !st_d.test2[scr_pkg::TEST2_HIZ];

    // Ready flags for the next cycle
    st_d.awready = !st_d.aw_hold && !st_d.bvalid;
    st_d.wready  = !st_d.w_hold && !st_d.bvalid;
    st_d.arready = !st_d.rvalid;
  end

  // Registered copy
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign scsi_data_out = st_q.data_out;
  assign scsi_data_oe  = st_q.data_oe;
  assign scsi_ctl_out  = st_q.ctl_out;
  assign scsi_ctl_oe   = st_q.ctl_oe;

  // Configuration fields straight from the registers
  assign cfg.xfer_period    = st_q.xfer[scr_pkg::XFER_PERIOD_LO +: 3];
  assign cfg.sync_div       = st_q.ctl3[scr_pkg::CTL3_DIV_LO +: 3];
  assign cfg.no_halt_on_err = st_q.ctl1[scr_pkg::CTL1_NO_HALT];
  assign cfg.loopback       = st_q.test2[scr_pkg::TEST2_LOOPBACK];
  assign cfg.low_level      = st_q.test2[scr_pkg::TEST2_LOW_LEVEL];
  assign cfg.offset_reset   = st_q.ofs_rst;
  assign cfg.clk_halt       = st_q.clk_halt;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_taken(logic [9:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == idx;
  endsequence

  sequence s_wr_both;
    st_q.aw_hold && st_q.w_hold;
  endsequence

  a_rx_capture: assert property (rx_strobe |=> st_q.in_latch == $past(bus_view))
    else $error("input latch missed the strobe");
  a_tx_drive: assert property (tx_active && !st_q.test2[scr_pkg::TEST2_HIZ]
                               ##1 !st_q.test2[scr_pkg::TEST2_HIZ] |-> scsi_data_oe)
    else $error("send did not drive the data lines");
  a_tx_data: assert property (scsi_data_oe |-> scsi_data_out == st_q.out_latch)
    else $error("driven data differs from output latch");
  a_bus_live: assert property (s_rd_taken(scr_pkg::IDX_BUS_LINES)
                               ##0 !st_q.test2[scr_pkg::TEST2_LOOPBACK]
                               |=> s_axi_rdata[15:0] == $past(scsi_data_in))
    else $error("bus lines read was not the live value");
  a_dest_read: assert property (s_rd_taken(scr_pkg::IDX_DEST_ID)
                                |=> s_axi_rvalid && s_axi_rdata[7:0] == st_q.dest_id)
    else $error("destination id read wrong");
  a_sist_sticky: assert property (events.gross_err |=> st_q.evt0[scr_pkg::EVT_GROSS_ERR])
    else $error("gross error event lost");
  a_hiz_quiet: assert property (st_q.test2[scr_pkg::TEST2_HIZ] |-> !scsi_data_oe && !scsi_ctl_oe)
    else $error("outputs driven in high impedance mode");
  a_dir_bit: assert property (s_rd_taken(scr_pkg::IDX_CT2)
                              |=> s_axi_rdata[7] == $past(st_q.data_oe))
    else $error("direction bit wrong");
  a_ofs_pulse: assert property (cfg.offset_reset |=> !cfg.offset_reset)
    else $error("offset reset longer than one cycle");
  a_wr_answer: assert property (s_wr_both |=> s_axi_bvalid && !st_q.aw_hold)
    else $error("write not answered");
  a_scratch_hold: assert property (!(st_q.aw_hold && st_q.w_hold)
                                   |=> st_q.scratch2 == $past(st_q.scratch2))
    else $error("scratch changed without a write");

endmodule : scr_regmap

`default_nettype wire

// ---- scr_bus_model.sv ----
// SCSI bus partner: drives the data lines and the receive strobe
`timescale 1ns/1ps
`default_nettype none
module scr_bus_model
(
  // Clock
  input  wire logic        aclk,
  // Data lines
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  output logic      [15:0] data_in,
  output var logic         rx_strobe
);
  logic [15:0] word_q = 16'h0000;
  initial rx_strobe = 1'b0;
  // Wire level: the device's drive wins over the far side
  assign data_in = data_oe ? data_out : word_q;
  // Place a word, let it settle, then strobe it if asked
  task automatic put(input logic [15:0] w, input logic stb);
    word_q <= w;
    repeat (3) @(posedge aclk);
    rx_strobe <= stb;
    @(posedge aclk);
    rx_strobe <= 1'b0;
  endtask
endmodule // scr_bus_model
`default_nettype wire

// ---- scr_regmap_tb.sv ----
// Self-checking bench of the SCSI core register map
`timescale 1ns/1ps
`default_nettype none
module scr_regmap_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scsi_clk;
  logic scsi_data_oe, scsi_ctl_oe, rx_strobe, tx_active, ctl_drive, fifo_parity_lo;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [15:0] scsi_data_in, scsi_data_out;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  scsi_ctl_out;
  scr_pkg::scr_evt_type events;
  scr_pkg::scr_cfg_type cfg;
  int err_count = 0;
  int check_count = 0;
  scr_regmap i_scr_regmap (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .scsi_data_in, .scsi_data_out, .scsi_data_oe, .scsi_ctl_out,
    .scsi_ctl_oe, .rx_strobe, .tx_active, .ctl_drive, .fifo_parity_lo, .events, .cfg, .scsi_clk);
  scr_bus_model i_scr_bus_model (.aclk, .data_out(scsi_data_out), .data_oe(scsi_data_oe),
    .data_in(scsi_data_in), .rx_strobe);
  // 40 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One AXI4-Lite access; valids drop as taken, ready held until the answer
  task automatic acc(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    int n;
    s_axi_awaddr  <= {idx, 2'h0};
    s_axi_araddr  <= {idx, 2'h0};
    s_axi_wdata   <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid  <= wr;
    s_axi_bready  <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready  <= !wr;
    for (n = 0; n < 40; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (wr ? s_axi_bvalid : s_axi_rvalid)
        break;
    end
    rd = s_axi_rdata;
    r  = wr ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (n == 40)
    begin
      err_count++;
      $display("unexpected at %0t: bus timeout", $time);
      end_of_test();
    end
  endtask
  // Write expecting OKAY, read expecting a value and OKAY
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    acc(1'b1, idx, d);
    chk(32'(r), 32'(scr_pkg::RESP_OKAY));
  endtask
  task automatic rc(input logic [9:0] idx, input logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    chk(rd, exp);
    chk(32'(r), 32'(scr_pkg::RESP_OKAY));
  endtask
  // Registers at their indices, unmapped place refused
  task automatic t_regs();
    wr(scr_pkg::IDX_SCRATCH2, 32'hC3A5_5A3C);
    rc(scr_pkg::IDX_SCRATCH2, 32'hC3A5_5A3C);
    wr(scr_pkg::IDX_DEST_ID, 32'h61);
    wr(scr_pkg::IDX_INT_EN, 32'h92);
    wr(scr_pkg::IDX_CT0, 32'hEE);
    rc(scr_pkg::IDX_DEST_ID, 32'h61);
    rc(scr_pkg::IDX_INT_EN, 32'h92);
    rc(scr_pkg::IDX_CT0, 32'hEE);
    rc(scr_pkg::IDX_INT_STATUS, 32'h0);
    acc(1'b1, 10'h3FF, 32'h5);
    chk(32'(r), 32'(scr_pkg::RESP_SLVERR));
  endtask
  // Config fields, loopback, offset reset self-clear
  task automatic t_fields();
    wr(scr_pkg::IDX_XFER, 32'hA0);
    chk(32'(cfg.xfer_period), 32'h5);
    wr(scr_pkg::IDX_CTL1, 32'h20);
    chk(32'(cfg.no_halt_on_err), 32'h1);
    wr(scr_pkg::IDX_CTL3, 32'h50);
    chk(32'(cfg.sync_div), 32'h5);
    wr(scr_pkg::IDX_OUT_LATCH, 32'hBEEF);
    wr(scr_pkg::IDX_TEST2, 32'h51);
    chk(32'({cfg.loopback, cfg.low_level}), 32'h3);
    rc(scr_pkg::IDX_TEST2, 32'h11);
    rc(scr_pkg::IDX_BUS_LINES, 32'hBEEF);
    wr(scr_pkg::IDX_TEST2, 32'h0);
  endtask
  // Send drive, direction bit, high impedance
  task automatic t_out();
    wr(scr_pkg::IDX_OUT_CTL, 32'h3C);
    tx_active <= 1'b1;
    ctl_drive <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(32'({scsi_data_oe, scsi_ctl_oe, scsi_ctl_out, scsi_data_out}), 32'h33CBEEF);
    rc(scr_pkg::IDX_CT2, 32'h80);
    wr(scr_pkg::IDX_TEST2, 32'h08);
    chk(32'({scsi_data_oe, scsi_ctl_oe}), 32'h0);
    wr(scr_pkg::IDX_TEST2, 32'h0);
    tx_active <= 1'b0;
    ctl_drive <= 1'b0;
  endtask
  // Latched receive word against live lines
  task automatic t_in();
    i_scr_bus_model.put(16'h5AC3, 1'b1);
    i_scr_bus_model.put(16'h1234, 1'b0);
    rc(scr_pkg::IDX_IN_LATCH, 32'h5AC3);
    rc(scr_pkg::IDX_BUS_LINES, 32'h1234);
    fifo_parity_lo <= 1'b1;
    rc(scr_pkg::IDX_TEST1, 32'h1);
  endtask
  // Event bits set, then cleared by a read
  task automatic t_evt(input logic [4:0] e, input logic [31:0] exp);
    events <= e;
    @(posedge aclk);
    events <= 5'h0;
    rc(scr_pkg::IDX_EVT0, exp);
    rc(scr_pkg::IDX_EVT0, 32'h0);
  endtask
  // High cycles of the SCSI clock in 12 cycles; a two-cycle high adds 100
  task automatic clk_run(input int exp);
    int hi;
    logic last;
    hi = 0;
    last = 1'b0;
    repeat (12)
    begin
      @(posedge aclk);
      hi += (scsi_clk && last) ? 100 : int'(scsi_clk);
      last = scsi_clk;
    end
    chk(hi, exp);
  endtask
  // Stimulus
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {tx_active, ctl_drive, fifo_parity_lo} = 3'h0;
    s_axi_wstrb = 4'hF;
    events = 5'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_fields();
    t_out();
    t_in();
    t_evt(5'b10010, 32'h42);
    t_evt(5'b01101, 32'h8C);
    clk_run(6);
    wr(scr_pkg::IDX_CLK_CTL, 32'h1);
    clk_run(0);
    chk(32'(cfg.clk_halt), 32'h1);
    rc(scr_pkg::IDX_CLK_CTL, 32'h3);
    wr(scr_pkg::IDX_CLK_CTL, 32'h0);
    clk_run(6);
    wr(scr_pkg::IDX_DEST_ID, 32'h2B);
    rc(scr_pkg::IDX_DEST_ID, 32'h2B);
    end_of_test();
  end
endmodule // scr_regmap_tb
`default_nettype wire
